// File: shared/tlb_assist_pkg.sv
// Constants for the miss-assist register block and the extra block translation arrays.
// Assumes the core gives register numbers, miss events and translation lookups on the core clock.
// Function
// - Miss sets compare valid bit
// - Miss copies segment ID into compare
// - Miss clears hash function bit
// - Miss copies page index into compare
// - TLB load writes compare plus address
// - Compare registers readable and writable
// - Hash registers give primary, secondary groups
// - Table origin top bits into hashes
// - Hashed bits six to 24, low zero
// - Hashes read-only, from latest miss
// - Software loads physical word, merged
// - Referenced bit dropped on TLB write
// - Physical word field layout, read/write
// - Four extra instruction, data block entries
// - Extra blocks translate only when enabled
// - Block registers supervisor access, always
// - Entry is upper and lower pair
// - Block start, size from number, mask
package tlb_assist_pkg;
   // Register numbers for the move instructions
   localparam logic [9:0]  SPR_DATA_MISS   = 10'h3d0;
   localparam logic [9:0]  SPR_DATA_CMP    = 10'h3d1;
   localparam logic [9:0]  SPR_PRIMARY     = 10'h3d2;
   localparam logic [9:0]  SPR_SECONDARY   = 10'h3d3;
   localparam logic [9:0]  SPR_INSTR_MISS  = 10'h3d4;
   localparam logic [9:0]  SPR_INSTR_CMP   = 10'h3d5;
   localparam logic [9:0]  SPR_PHYS        = 10'h3d6;
   localparam logic [9:0]  SPR_IBLK_BASE   = 10'h230;
   localparam logic [9:0]  SPR_DBLK_BASE   = 10'h238;
   // Compare word fields (index 31 is the leftmost bit)
   localparam int          CMP_VALID       = 31;
   localparam int          CMP_SEG_HI      = 30;
   localparam int          CMP_SEG_LO      = 7;
   localparam int          CMP_HASH_ID     = 6;
   localparam int          CMP_PGIX_HI     = 5;
   localparam int          CMP_UPPER_LO    = 7;
   // Effective address fields
   localparam int          EA_PGIX_HI      = 27;
   localparam int          EA_PGIX_LO      = 22;
   localparam int          EA_PIDX_HI      = 27;
   localparam int          EA_PIDX_LO      = 12;
   localparam int          EA_TAG_HI       = 27;
   localparam int          EA_TAG_LO       = 17;
   // Physical address word fields
   localparam int          PA_PPN_HI       = 31;
   localparam int          PA_PPN_LO       = 12;
   localparam int          PA_REF          = 8;
   localparam int          PA_CHG          = 7;
   localparam int          PA_ATTR_HI      = 6;
   localparam int          PA_ATTR_LO      = 3;
   localparam logic [31:0] PA_WR_MASK      = 32'hfffff1fb;
   // Page table base fields
   localparam int          PTB_ORG_HI      = 31;
   localparam int          PTB_ORG_SPLIT   = 25;
   localparam int          PTB_ORGL_HI     = 24;
   localparam int          PTB_ORGL_LO     = 16;
   localparam int          PTB_MASK_HI     = 8;
   // Block entry fields
   localparam int          BLK_EPI_HI      = 31;
   localparam int          BLK_EPI_LO      = 17;
   localparam int          BLK_LEN_HI      = 12;
   localparam int          BLK_LEN_LO      = 2;
   localparam int          BLK_VS          = 1;
   localparam int          BLK_VP          = 0;
   localparam logic [31:0] BLK_UP_MASK     = 32'hfffe1fff;
   localparam logic [31:0] BLK_LO_MASK     = 32'hfffe007b;
   localparam int          BLK_ENTRIES     = 4;
   // Reset values
   localparam logic [31:0] REG_RESET       = 32'h00000000;
endpackage : tlb_assist_pkg

// File: shared/blk_lookup_if.sv
// Carrier between the register block and one block translation matcher.
// Assumes both ends run on the core clock; the matcher is combinational.
`timescale 1ns/10ps
interface blk_lookup_if #(parameter int ENTRIES = 4);
   logic [31:0]              ea;
   logic                     supervisor;
   logic                     enable;
   logic [ENTRIES-1:0][31:0] upper;
   logic [ENTRIES-1:0][31:0] lower;
   logic                     hit;
   logic [31:0]              pa;
   logic [3:0]               attr;
   logic [1:0]               prot;
   modport owner   (output ea, supervisor, enable, upper, lower, input hit, pa, attr, prot);
   modport matcher (input ea, supervisor, enable, upper, lower, output hit, pa, attr, prot);
endinterface : blk_lookup_if

// File: rtl/blk_match.sv
// Combinational matcher over one array of block translation entries.
// Assumes entry words follow the upper/lower layout in the package; lowest entry wins.
`timescale 1ns/10ps
module blk_match #(
   parameter int ENTRIES = 4
) (
   // Lookup carrier
   blk_lookup_if.matcher lk
);
   initial begin
      if (ENTRIES < 1 || ENTRIES > 8) begin
         $error("blk_match: ENTRIES must be 1 to 8");
      end
   end

   // Scan entries from the top down; the last valid match, the lowest entry, gives the translation
   always_comb begin
      logic [10:0] len;
      logic [14:0] epi;
      logic [14:0] bpn;
      logic        vld;
      len     = '0;
      epi     = '0;
      bpn     = '0;
      vld     = 1'b0;
      lk.hit  = 1'b0;
      lk.pa   = '0;
      lk.attr = '0;
      lk.prot = '0;
      for (int e = ENTRIES - 1; e >= 0; e--) begin
         len = lk.upper[e][tlb_assist_pkg::BLK_LEN_HI:tlb_assist_pkg::BLK_LEN_LO];
         epi = lk.upper[e][tlb_assist_pkg::BLK_EPI_HI:tlb_assist_pkg::BLK_EPI_LO];
         bpn = lk.lower[e][tlb_assist_pkg::BLK_EPI_HI:tlb_assist_pkg::BLK_EPI_LO];
         vld = lk.supervisor ? lk.upper[e][tlb_assist_pkg::BLK_VS] : lk.upper[e][tlb_assist_pkg::BLK_VP];
         // Mask covers up to 256 Mbytes; top four bits always compared
         if (lk.enable && vld && lk.ea[31:28] == epi[14:11] &&
             (lk.ea[27:17] & ~len) == (epi[10:0] & ~len)) begin
            lk.hit  = 1'b1;
            lk.pa   = {bpn[14:11], bpn[10:0] | (lk.ea[27:17] & len), lk.ea[16:0]};
            lk.attr = lk.lower[e][tlb_assist_pkg::PA_ATTR_HI:tlb_assist_pkg::PA_ATTR_LO];
            lk.prot = lk.lower[e][1:0];
         end
      end
   end
endmodule : blk_match

// File: rtl/tlb_miss_assist_regs.sv
// Miss-assist registers and the extra block translation arrays of the memory unit.
// Assumes the core presents move-instruction accesses, miss events, TLB load requests and
// translation lookups as single-cycle requests on core_clk; segment lookup is done by the core.
`timescale 1ns/10ps
module tlb_miss_assist_regs #(
   parameter int BAT_ENTRIES = tlb_assist_pkg::BLK_ENTRIES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Special-register moves
   input  wire logic        spr_wr_en,
   input  wire logic        spr_rd_en,
   input  wire logic [9:0]  spr_num,
   input  wire logic [31:0] spr_wdata,
   input  wire logic        spr_supervisor,
   output      logic        spr_hit,
   output      logic        spr_rd_ack,
   output      logic [31:0] spr_rdata,
   output      logic        spr_priv_error,
   // Miss event from translation
   input  wire logic        miss_valid,
   input  wire logic        miss_is_instr,
   input  wire logic [31:0] miss_ea,
   input  wire logic [23:0] virtual_segment_id,
   // Page table base and high block enable
   input  wire logic [31:0] page_table_base_reg,
   input  wire logic        high_block_enable,
   // TLB load instructions
   input  wire logic        tlb_load_valid,
   input  wire logic        tlb_load_is_instr,
   output      logic        tlb_write_valid,
   output      logic        tlb_write_is_instr,
   output      logic [35:0] tlb_write_word0,
   output      logic [26:0] tlb_write_word1,
   // Block translation lookups
   input  wire logic [31:0] ixlate_ea,
   input  wire logic [31:0] dxlate_ea,
   input  wire logic        xlate_supervisor,
   output      logic        ixlate_hit,
   output      logic [31:0] ixlate_pa,
   output      logic [3:0]  ixlate_attr,
   output      logic [1:0]  ixlate_prot,
   output      logic        dxlate_hit,
   output      logic [31:0] dxlate_pa,
   output      logic [3:0]  dxlate_attr,
   output      logic [1:0]  dxlate_prot
);
   initial begin
      if (BAT_ENTRIES < 1 || BAT_ENTRIES > 4) begin
         $error("tlb_miss_assist_regs: BAT_ENTRIES must be 1 to 4");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0]                         dm_ea;
      logic [31:0]                         im_ea;
      logic [31:0]                         dcomp;
      logic [31:0]                         icomp;
      logic [31:0]                         phys;
      logic                                last_instr;
      logic [1:0][BAT_ENTRIES-1:0][31:0]   blk_up;
      logic [1:0][BAT_ENTRIES-1:0][31:0]   blk_lo;
      logic                                rd_ack;
      logic [31:0]                         rdata;
      logic                                priv_err;
      logic                                tlb_wr;
      logic                                tlb_wr_instr;
      logic [35:0]                         tlb_w0;
      logic [26:0]                         tlb_w1;
      logic                                ib_hit;
      logic [31:0]                         ib_pa;
      logic [3:0]                          ib_attr;
      logic [1:0]                          ib_prot;
      logic                                db_hit;
      logic [31:0]                         db_pa;
      logic [3:0]                          db_attr;
      logic [1:0]                          db_prot;
   } state_t;

   state_t      st_reg;
   state_t      st_next;
   logic [18:0] hash_primary;
   logic [18:0] hash_secondary;
   logic [31:0] primary_group_address;
   logic [31:0] secondary_group_address;
   logic        dec_hit;
   logic [31:0] dec_rdata;
   logic        dec_is_blk;
   logic        dec_blk_side;
   logic        dec_blk_half;
   int          dec_blk_idx;

   ////////////////////////////////////////////////////////////////////////////////
   // Block translation matchers

   blk_lookup_if #(.ENTRIES(BAT_ENTRIES)) ilk ();
   blk_lookup_if #(.ENTRIES(BAT_ENTRIES)) dlk ();

   // Extra entries take part only while enabled
   assign ilk.ea         = ixlate_ea;
   assign ilk.supervisor = xlate_supervisor;
   assign ilk.enable     = high_block_enable;
   assign ilk.upper      = st_reg.blk_up[0];
   assign ilk.lower      = st_reg.blk_lo[0];
   assign dlk.ea         = dxlate_ea;
   assign dlk.supervisor = xlate_supervisor;
   assign dlk.enable     = high_block_enable;
   assign dlk.upper      = st_reg.blk_up[1];
   assign dlk.lower      = st_reg.blk_lo[1];

   blk_match #(.ENTRIES(BAT_ENTRIES)) u_iblk (
      .lk (ilk.matcher)
   );

   blk_match #(.ENTRIES(BAT_ENTRIES)) u_dblk (
      .lk (dlk.matcher)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Hashed group addresses from the latest miss

   localparam int CMPV_LO_SEL = tlb_assist_pkg::CMP_SEG_LO;

   // Primary hash is segment ID XOR page index, secondary its complement
   always_comb begin
      logic [31:0] ea;
      logic [31:0] cmp;
      ea  = st_reg.last_instr ? st_reg.im_ea : st_reg.dm_ea;
      cmp = st_reg.last_instr ? st_reg.icomp : st_reg.dcomp;
      hash_primary   = cmp[CMPV_LO_SEL+18:CMPV_LO_SEL] ^
                       {3'h0, ea[tlb_assist_pkg::EA_PIDX_HI:tlb_assist_pkg::EA_PIDX_LO]};
      hash_secondary = ~hash_primary;
   end

   // Origin top bits, masked middle bits, zero low bits
   function automatic logic [31:0] group_addr(input logic [31:0] ptb, input logic [18:0] h);
      logic [8:0] mid;
      mid = ptb[tlb_assist_pkg::PTB_ORGL_HI:tlb_assist_pkg::PTB_ORGL_LO] |
            (h[18:10] & ptb[tlb_assist_pkg::PTB_MASK_HI:0]);
      return {ptb[tlb_assist_pkg::PTB_ORG_HI:tlb_assist_pkg::PTB_ORG_SPLIT], mid, h[9:0], 6'h00};
   endfunction : group_addr

   assign primary_group_address   = group_addr(page_table_base_reg, hash_primary);
   assign secondary_group_address = group_addr(page_table_base_reg, hash_secondary);

   ////////////////////////////////////////////////////////////////////////////////
   // Register number decode and read data

   // Decode block entry numbers: upper at even, lower at odd
   always_comb begin
      dec_is_blk   = 1'b0;
      dec_blk_side = 1'b0;
      dec_blk_half = 1'b0;
      dec_blk_idx  = 0;
      for (int e = 0; e < BAT_ENTRIES; e++) begin
         for (int h = 0; h < 2; h++) begin
            if (spr_num == tlb_assist_pkg::SPR_IBLK_BASE + 10'(2 * e + h)) begin
               dec_is_blk   = 1'b1;
               dec_blk_side = 1'b0;
               dec_blk_half = h[0];
               dec_blk_idx  = e;
            end
            if (spr_num == tlb_assist_pkg::SPR_DBLK_BASE + 10'(2 * e + h)) begin
               dec_is_blk   = 1'b1;
               dec_blk_side = 1'b1;
               dec_blk_half = h[0];
               dec_blk_idx  = e;
            end
         end
      end
   end

   // Read mux; unknown numbers are not claimed
   always_comb begin
      dec_hit   = 1'b1;
      dec_rdata = '0;
      case (spr_num)
         tlb_assist_pkg::SPR_DATA_MISS:  dec_rdata = st_reg.dm_ea;
         tlb_assist_pkg::SPR_INSTR_MISS: dec_rdata = st_reg.im_ea;
         tlb_assist_pkg::SPR_DATA_CMP:   dec_rdata = st_reg.dcomp;
         tlb_assist_pkg::SPR_INSTR_CMP:  dec_rdata = st_reg.icomp;
         tlb_assist_pkg::SPR_PRIMARY:    dec_rdata = primary_group_address;
         tlb_assist_pkg::SPR_SECONDARY:  dec_rdata = secondary_group_address;
         tlb_assist_pkg::SPR_PHYS:       dec_rdata = st_reg.phys;
         default: begin
            if (dec_is_blk) begin
               dec_rdata = dec_blk_half ? st_reg.blk_lo[dec_blk_side][dec_blk_idx]
                                        : st_reg.blk_up[dec_blk_side][dec_blk_idx];
            end else begin
               dec_hit = 1'b0;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic wr_ok;
      logic rd_ok;
      logic [31:0] lea;
      logic [31:0] lcmp;
      st_next = st_reg;
      wr_ok   = spr_wr_en && dec_hit && spr_supervisor;
      rd_ok   = spr_rd_en && dec_hit && spr_supervisor;
      lea     = tlb_load_is_instr ? st_reg.im_ea : st_reg.dm_ea;
      lcmp    = tlb_load_is_instr ? st_reg.icomp : st_reg.dcomp;

      // Read answer and privilege fault, one cycle after the request
      st_next.rd_ack   = rd_ok;
      st_next.rdata    = rd_ok ? dec_rdata : '0;
      st_next.priv_err = (spr_wr_en || spr_rd_en) && dec_hit && !spr_supervisor;

      // Software writes; hash registers ignore writes
      if (wr_ok) begin
         case (spr_num)
            tlb_assist_pkg::SPR_DATA_MISS:  st_next.dm_ea = spr_wdata;
            tlb_assist_pkg::SPR_INSTR_MISS: st_next.im_ea = spr_wdata;
            tlb_assist_pkg::SPR_DATA_CMP:   st_next.dcomp = spr_wdata;
            tlb_assist_pkg::SPR_INSTR_CMP:  st_next.icomp = spr_wdata;
            tlb_assist_pkg::SPR_PHYS:       st_next.phys  = spr_wdata & tlb_assist_pkg::PA_WR_MASK;
            default: begin
               if (dec_is_blk && dec_blk_half) begin
                  st_next.blk_lo[dec_blk_side][dec_blk_idx] = spr_wdata & tlb_assist_pkg::BLK_LO_MASK;
               end else if (dec_is_blk) begin
                  st_next.blk_up[dec_blk_side][dec_blk_idx] = spr_wdata & tlb_assist_pkg::BLK_UP_MASK;
               end
            end
         endcase
      end

      // Miss capture wins over a software write in the same cycle
      if (miss_valid) begin
         st_next.last_instr = miss_is_instr;
         if (miss_is_instr) begin
            st_next.im_ea = miss_ea;
            st_next.icomp = {1'b1, virtual_segment_id, 1'b0,
                             miss_ea[tlb_assist_pkg::EA_PGIX_HI:tlb_assist_pkg::EA_PGIX_LO]};
         end else begin
            st_next.dm_ea = miss_ea;
            st_next.dcomp = {1'b1, virtual_segment_id, 1'b0,
                             miss_ea[tlb_assist_pkg::EA_PGIX_HI:tlb_assist_pkg::EA_PGIX_LO]};
         end
      end

      // TLB load: compare upper bits plus address bits, physical word without referenced bit
      st_next.tlb_wr       = tlb_load_valid;
      st_next.tlb_wr_instr = tlb_load_valid && tlb_load_is_instr;
      if (tlb_load_valid) begin
         st_next.tlb_w0 = {lcmp[31:tlb_assist_pkg::CMP_UPPER_LO],
                           lea[tlb_assist_pkg::EA_TAG_HI:tlb_assist_pkg::EA_TAG_LO]};
         st_next.tlb_w1 = {st_reg.phys[tlb_assist_pkg::PA_PPN_HI:tlb_assist_pkg::PA_PPN_LO],
                           st_reg.phys[tlb_assist_pkg::PA_CHG:tlb_assist_pkg::PA_ATTR_LO],
                           st_reg.phys[1:0]};
      end

      // Registered block translation results
      st_next.ib_hit  = ilk.hit;
      st_next.ib_pa   = ilk.pa;
      st_next.ib_attr = ilk.attr;
      st_next.ib_prot = ilk.prot;
      st_next.db_hit  = dlk.hit;
      st_next.db_pa   = dlk.pa;
      st_next.db_attr = dlk.attr;
      st_next.db_prot = dlk.prot;
   end

   // State register; all fields clear on reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Access claim is combinational, data from flops
   assign spr_hit            = dec_hit && (spr_wr_en || spr_rd_en);
   assign spr_rd_ack         = st_reg.rd_ack;
   assign spr_rdata          = st_reg.rdata;
   assign spr_priv_error     = st_reg.priv_err;
   assign tlb_write_valid    = st_reg.tlb_wr;
   assign tlb_write_is_instr = st_reg.tlb_wr_instr;
   assign tlb_write_word0    = st_reg.tlb_w0;
   assign tlb_write_word1    = st_reg.tlb_w1;
   assign ixlate_hit         = st_reg.ib_hit;
   assign ixlate_pa          = st_reg.ib_pa;
   assign ixlate_attr        = st_reg.ib_attr;
   assign ixlate_prot        = st_reg.ib_prot;
   assign dxlate_hit         = st_reg.db_hit;
   assign dxlate_pa          = st_reg.db_pa;
   assign dxlate_attr        = st_reg.db_attr;
   assign dxlate_prot        = st_reg.db_prot;
endmodule : tlb_miss_assist_regs

// File: test/tlb_assist_sva.sv
// Concurrent checks on the miss-assist register block, bound onto its top module.
// Assumes one core_clk domain and the active-low asynchronous resetn.
`timescale 1ns/10ps
module tlb_assist_sva #(
   parameter int BAT_ENTRIES = 4
) (
   // Clock, reset and register moves
   input wire logic        core_clk, resetn, spr_wr_en, spr_rd_en, spr_supervisor,
   input wire logic [9:0]  spr_num,
   input wire logic        spr_hit, spr_rd_ack, spr_priv_error,
   input wire logic [31:0] spr_rdata,
   // Miss, table base and TLB load
   input wire logic        miss_valid, miss_is_instr, high_block_enable,
   input wire logic [31:0] miss_ea, page_table_base_reg,
   input wire logic [23:0] virtual_segment_id,
   input wire logic        tlb_load_valid, tlb_load_is_instr, tlb_write_valid, tlb_write_is_instr,
   // Block lookups
   input wire logic [31:0] dxlate_ea, dxlate_pa,
   input wire logic        dxlate_hit, ixlate_hit
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Allowed read of one of our registers
   wire rd_ok = spr_rd_en && spr_hit && spr_supervisor;
   ////////////////////////////////////////////////////////////////////////////////
   a_read_ack: assert property (rd_ok |=> spr_rd_ack) else $error("read not acknowledged");
   a_rdata_idle: assert property (!spr_rd_ack |-> spr_rdata == 32'h0) else $error("read data without ack");
   a_priv_refuse: assert property ((spr_rd_en || spr_wr_en) && spr_hit && !spr_supervisor
      |=> spr_priv_error && !spr_rd_ack) else $error("user access not refused");
   a_cmp_fill: assert property (miss_valid && !miss_is_instr ##1 !miss_valid && !spr_wr_en
      ##1 rd_ok && !spr_wr_en && spr_num == tlb_assist_pkg::SPR_DATA_CMP
      |=> spr_rdata == {1'b1, $past(virtual_segment_id, 3), 1'b0, $past(miss_ea[27:22], 3)})
      else $error("compare word not built from miss");
   a_hash_frame: assert property (rd_ok && spr_num == tlb_assist_pkg::SPR_PRIMARY
      |=> spr_rdata[31:25] == $past(page_table_base_reg[31:25]) && spr_rdata[5:0] == 6'h00)
      else $error("group address frame wrong");
   a_tlb_pulse: assert property (tlb_load_valid |=> tlb_write_valid &&
      tlb_write_is_instr == $past(tlb_load_is_instr)) else $error("TLB write missing");
   a_tlb_quiet: assert property (!tlb_load_valid |=> !tlb_write_valid) else $error("stray TLB write");
   a_blk_gate: assert property (!high_block_enable |=> !dxlate_hit && !ixlate_hit) else $error("block hit while off");
   a_blk_offset: assert property (dxlate_hit |-> dxlate_pa[16:0] == $past(dxlate_ea[16:0]))
      else $error("block offset not passed");
   // Main scenarios reached
   c_miss: cover property (miss_valid && !miss_is_instr);
   c_tlb: cover property (tlb_write_valid);
   c_blk: cover property (dxlate_hit);
   c_priv: cover property (spr_priv_error);
endmodule : tlb_assist_sva

bind tlb_miss_assist_regs tlb_assist_sva #(.BAT_ENTRIES(BAT_ENTRIES)) u_sva (.*);

// File: test/core_side_model.sv
// Core-side model: segment file, page table base and high block enable.
// Assumes the bench picks the enable level; segment lookup is combinational.
`timescale 1ns/10ps
module core_side_model (
   // From the bench
   input  wire logic [31:0] miss_ea,
   input  wire logic        blk_en_req,
   // To the block
   output      logic [23:0] virtual_segment_id,
   output      logic [31:0] page_table_base_reg,
   output      logic        high_block_enable
);
   // Sixteen segments selected by the top four address bits
   assign virtual_segment_id  = 24'h3c5a00 + 24'(miss_ea[31:28] * 8'h11);
   // Origin with a full mask, so hashed high bits fold in
   assign page_table_base_reg = 32'habc0_01ff;
   assign high_block_enable   = blk_en_req;
endmodule : core_side_model

// File: test/tlb_miss_assist_regs_tb_top.sv
// Self-checking bench for the miss-assist register block.
// Assumes the core-side model supplies segment, table base and block enable.
`timescale 1ns/10ps
module tlb_miss_assist_regs_tb_top;
   logic        core_clk, resetn, spr_wr_en, spr_rd_en, spr_supervisor, spr_hit, spr_rd_ack, spr_priv_error;
   logic        miss_valid, miss_is_instr, tlb_load_valid, tlb_load_is_instr, tlb_write_valid, tlb_write_is_instr;
   logic        xlate_supervisor, blk_en_req, high_block_enable, ixlate_hit, dxlate_hit, ack, perr, hit;
   logic [9:0]  spr_num;
   logic [31:0] spr_wdata, spr_rdata, miss_ea, ixlate_ea, dxlate_ea, ixlate_pa, dxlate_pa, page_table_base_reg, rd;
   logic [23:0] virtual_segment_id;
   logic [3:0]  ixlate_attr, dxlate_attr;
   logic [1:0]  ixlate_prot, dxlate_prot;
   logic [35:0] tlb_write_word0;
   logic [26:0] tlb_write_word1;
   logic [31:0] cmp [2];
   logic [31:0] mea [2];
   int          errors, tests_run;
   tlb_miss_assist_regs #(.BAT_ENTRIES(4)) dut (.*);
   core_side_model core (.*);
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("counts: tests_run=%0d errors=%0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   // One register move, held for one edge
   task automatic spr_op(input logic wr, input logic [9:0] num, input logic [31:0] data, input logic sup);
      @(posedge core_clk);
      #1;
      spr_wr_en = wr;
      spr_rd_en = ~wr;
      spr_num = num;
      spr_wdata = data;
      spr_supervisor = sup;
      #1;
      hit = spr_hit;
      @(posedge core_clk);
      #1;
      spr_wr_en = 1'b0;
      spr_rd_en = 1'b0;
      rd = spr_rdata;
      ack = spr_rd_ack;
      perr = spr_priv_error;
   endtask : spr_op
   task automatic rdc(input logic [9:0] num, input logic [31:0] exp);
      spr_op(1'b0, num, 32'h0, 1'b1);
      chk(ack, 1'b1);
      chk(rd, exp);
   endtask : rdc
   task automatic miss(input logic side, input logic [31:0] ea);
      @(posedge core_clk);
      #1;
      miss_valid = 1'b1;
      miss_is_instr = side;
      miss_ea = ea;
      @(posedge core_clk);
      #1;
      miss_valid = 1'b0;
      mea[side] = ea;
      cmp[side] = {1'b1, 24'h3c5a00 + 24'(ea[31:28] * 8'h11), 1'b0, ea[27:22]};
   endtask : miss
   function automatic logic [31:0] grp(input logic side, input logic sec);
      logic [18:0] h;
      h = cmp[side][25:7] ^ {3'h0, mea[side][27:12]};
      if (sec) h = ~h;
      return {page_table_base_reg[31:25], page_table_base_reg[24:16] | (h[18:10] & page_table_base_reg[8:0]),
              h[9:0], 6'h00};
   endfunction : grp
   // Watchdog
   initial begin
      #200000;
      errors++;
      give_verdict();
   end
   // Tests
   initial begin
      {spr_wr_en, spr_rd_en, spr_supervisor, miss_valid, miss_is_instr, tlb_load_valid} = 6'h00;
      {tlb_load_is_instr, xlate_supervisor, blk_en_req} = 3'h0;
      {spr_num, spr_wdata, miss_ea, ixlate_ea, dxlate_ea} = 138'h0;
      errors = 0;
      tests_run = 0;
      resetn = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      miss(1'b0, 32'h7123_4567);
      rdc(tlb_assist_pkg::SPR_DATA_CMP, cmp[0]);
      rdc(tlb_assist_pkg::SPR_INSTR_CMP, 32'h0);
      rdc(tlb_assist_pkg::SPR_PRIMARY, grp(1'b0, 1'b0));
      rdc(tlb_assist_pkg::SPR_SECONDARY, grp(1'b0, 1'b1));
      spr_op(1'b1, tlb_assist_pkg::SPR_PRIMARY, 32'hffff_ffff, 1'b1);
      rdc(tlb_assist_pkg::SPR_PRIMARY, grp(1'b0, 1'b0));
      miss(1'b1, 32'h9abc_def0);
      rdc(tlb_assist_pkg::SPR_INSTR_CMP, cmp[1]);
      rdc(tlb_assist_pkg::SPR_DATA_CMP, cmp[0]);
      rdc(tlb_assist_pkg::SPR_SECONDARY, grp(1'b1, 1'b1));
      $display("test miss_and_group done");
      cmp[0] = 32'h1234_5678;
      spr_op(1'b1, tlb_assist_pkg::SPR_DATA_CMP, cmp[0], 1'b1);
      rdc(tlb_assist_pkg::SPR_DATA_CMP, cmp[0]);
      spr_op(1'b1, tlb_assist_pkg::SPR_PHYS, 32'hffff_ffff, 1'b1);
      rdc(tlb_assist_pkg::SPR_PHYS, 32'hffff_f1fb);
      spr_op(1'b1, tlb_assist_pkg::SPR_PHYS, 32'ha5a5_a1ab, 1'b1);
      for (int s = 0; s < 2; s++) begin
         @(posedge core_clk);
         #1;
         tlb_load_valid = 1'b1;
         tlb_load_is_instr = s[0];
         @(posedge core_clk);
         #1;
         tlb_load_valid = 1'b0;
         chk({tlb_write_valid, tlb_write_is_instr}, {1'b1, s[0]});
         chk(tlb_write_word0, {cmp[s][31:7], mea[s][27:17]});
         chk(tlb_write_word1, {20'ha5a5a, 5'h15, 2'h3});
      end
      $display("test tlb_load done");
      spr_op(1'b1, 10'h238, 32'h8000_000e, 1'b1);
      spr_op(1'b1, 10'h239, 32'h1234_002a, 1'b1);
      spr_op(1'b1, 10'h230, 32'hffff_ffff, 1'b1);
      spr_op(1'b1, 10'h231, 32'hffff_ffa7, 1'b1);
      rdc(10'h230, 32'hfffe_1fff);
      rdc(10'h231, 32'hfffe_0023);
      spr_op(1'b0, 10'h238, 32'h0, 1'b0);
      chk({perr, ack}, 2'h2);
      spr_op(1'b0, 10'h000, 32'h0, 1'b1);
      chk({hit, ack}, 2'h0);
      dxlate_ea = 32'h8006_5678;
      ixlate_ea = 32'hf123_4567;
      for (int e = 0; e < 3; e++) begin
         blk_en_req = (e != 0);
         xlate_supervisor = (e == 1);
         @(posedge core_clk);
         #1;
         @(posedge core_clk);
         #1;
         chk(dxlate_hit, e == 1);
         chk(ixlate_hit, e != 0);
         if (e == 1) begin
            chk({dxlate_pa, dxlate_attr, dxlate_prot}, {32'h1236_5678, 4'h5, 2'h2});
            chk({ixlate_pa, ixlate_attr, ixlate_prot}, {32'hffff_4567, 4'h4, 2'h3});
         end
      end
      $display("test block_xlate done");
      give_verdict();
   end
endmodule : tlb_miss_assist_regs_tb_top
